// ---- inc/bfm_pkg.sv ----
// Purpose: constants and types for the burst and fault mode controller
// Assumes: 10 MHz core clock; every count is derived from a time and the clock period
// Notes:   comparator inputs travel as one vector, indexed by the IDX_ names below
package bfm_pkg;

    // core clock
    localparam int CLK_PERIOD_NS = 100;

    // times as printed, in their own units
    localparam int T_BLANK_MS = 20;       // light-load and overload blanking
    localparam int T_SPIKE_US = 30;       // spike blanking after every fault condition
    localparam int T_OVP_HI_US = 120;     // high supply over-voltage qualification
    localparam int T_UV_MS = 10;          // supply under-voltage qualification
    localparam int T_EXT_BLANK_MS = 1;    // external restart request ignored after start

    // least times, rounded up to whole cycles
    localparam int BLANK_CYC = (T_BLANK_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SPIKE_CYC = (T_SPIKE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OVP_HI_CYC =
        ((T_OVP_HI_US + T_SPIKE_US) * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int UV_CYC =
        (T_UV_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SPIKE_CYC;
    localparam int EXT_BLANK_CYC = (T_EXT_BLANK_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // counter widths
    localparam int LONG_W = 18;
    localparam int SHORT_W = 11;

    // comparator vector layout
    localparam int N_CMP = 10;
    localparam int IDX_LIGHT = 0;     // feedback under 1.35 V
    localparam int IDX_BHIGH = 1;     // feedback over 3.5 V
    localparam int IDX_BLOW = 2;      // feedback under 3.0 V
    localparam int IDX_OVL = 3;       // feedback over 4.0 V
    localparam int IDX_RAMP = 4;      // blanking-adjust over 4.0 V
    localparam int IDX_EXT = 5;       // blanking-adjust under 0.33 V
    localparam int IDX_OV_SS = 6;     // supply over 20.5 V
    localparam int IDX_OV_HI = 7;     // supply over 25.5 V
    localparam int IDX_UNDER = 8;     // supply under 10.5 V (turn-off level)
    localparam int IDX_TURN_ON = 9;   // supply at turn-on level
    localparam int IDX_OT = 10;       // thermal monitor (top bit of the sync vector, index N_CMP)

    // short qualification timers
    localparam int N_SHORT = 5;
    localparam int SQ_OVP_SS = 0;
    localparam int SQ_OVP_HI = 1;
    localparam int SQ_OT = 2;
    localparam int SQ_EXT = 3;
    localparam int SQ_SPIKE = 4;
    localparam logic [N_SHORT-1:0][SHORT_W-1:0] SHORT_LIM = '{
        SHORT_W'(SPIKE_CYC), SHORT_W'(SPIKE_CYC), SHORT_W'(SPIKE_CYC),
        SHORT_W'(OVP_HI_CYC), SHORT_W'(SPIKE_CYC)};

    // operating states
    typedef enum logic [2:0] {
        ST_SOFT_START,
        ST_NORMAL,
        ST_BURST_OFF,
        ST_BURST_ON,
        ST_RST_WAIT,
        ST_RST_CHARGE
    } bfm_state_t;

    // whole controller state
    typedef struct packed {
        bfm_state_t st;
        logic [LONG_W-1:0] ll_cnt;
        logic [LONG_W-1:0] ol_cnt;
        logic [LONG_W-1:0] uv_cnt;
        logic [LONG_W-1:0] start_cnt;
        logic [N_SHORT-1:0][SHORT_W-1:0] sh_cnt;
        logic burst_flag;
        logic bias_en;
        logic startup_en;
        logic reduced_sel;
        logic clamp_release;
        logic soft_start_en;
        logic ext_stop;
        logic gate_ok;
        logic restart;
    } bfm_ctl_t;

endpackage : bfm_pkg

// ---- inc/bfm_sync_if.sv ----
// Purpose: carries raw comparator levels to the synchroniser and the clean copies back
// Assumes: one clock domain; the width is set by the user
// Notes:   src is the controller side, syn the synchroniser side
`timescale 1ns/1ps
interface bfm_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport src (output raw, input sync);
    modport syn (input raw, output sync);
endinterface : bfm_sync_if

// ---- rtl/bfm_sync.sv ----
// Purpose: two-flop synchroniser bank for the analog comparator outputs
// Assumes: raw levels are asynchronous to clk
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
module bfm_sync #(
    parameter int W = 1
) (
    input logic clk,
    input logic rst_n,
    bfm_sync_if.syn sif
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } bfm_sync_st_t;

    bfm_sync_st_t state_reg;
    bfm_sync_st_t state_next;

    // shift each level through two stages
    always_comb begin
        state_next = state_reg;
        state_next.s1 = sif.raw;
        state_next.s2 = state_reg.s1;
    end

    // register the stages, cleared by reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sif.sync = state_reg.s2;

endmodule : bfm_sync

// ---- rtl/bfm_ctrl.sv ----
// Purpose: burst mode and auto-restart control of a flyback switching controller
// Assumes: comparator outputs are asynchronous; soft_start_done and pwm_latch_q are on clk
// Notes:   all qualification times are cycle counts at 10 MHz
//
// Overview of operation
// - light-load counter clears one cycle after normal operation ends
// - burst entry after 20 ms under 1.35 V
// - burst entry sets flag, switches bias off
// - startup source stays off during burst
// - above 3.5 V bias returns, switching resumes
// - burst selects reduced 0.34 V current limit
// - under 3.0 V bias switches off again
// - above 4.0 V burst ends, full limit
// - soft-start over-voltage with feedback high, 30 us
// - supply over 25.5 V for 150 us, except in burst
// - over-temperature for 30 us enters restart
// - feedback over 4.0 V 20 ms releases clamp
// - clamp holds blanking pin until released
// - overload plus ramp high, 30 us more
// - supply under 10.5 V for 10.03 ms
// - external low request stops gate, restarts
// - external request ignored first 1 ms
// - only overload uses the extendable blanking
// - restart: off, charge, power up, soft start
// - faults rechecked after each startup phase
// - soft start on every restart attempt
`timescale 1ns/1ps
module bfm_ctrl
    import bfm_pkg::*;
#(
    parameter int BLANK_CYCLES = bfm_pkg::BLANK_CYC,
    parameter int UV_CYCLES = bfm_pkg::UV_CYC,
    parameter int EXT_BLANK_CYCLES = bfm_pkg::EXT_BLANK_CYC
) (
    input logic clk,
    input logic rst_n,
    input logic light_load_comparator,
    input logic burst_high_comparator,
    input logic burst_low_comparator,
    input logic overload_comparator,
    input logic ramp_level_comparator,
    input logic ext_restart_level,
    input logic supply_softstart_over,
    input logic supply_over_comparator,
    input logic supply_under,
    input logic supply_turn_on,
    input logic over_temp,
    input logic soft_start_done,
    input logic pwm_latch_q,
    output logic gate_req,
    output logic burst_flag,
    output logic bias_en,
    output logic startup_cell_en,
    output logic reduced_limit_gate,
    output logic clamp_release_switch,
    output logic soft_start_en,
    output logic auto_restart
);
    import bfm_pkg::*;

    localparam logic [LONG_W-1:0] BLANK_LIM = LONG_W'(BLANK_CYCLES);
    localparam logic [LONG_W-1:0] UV_LIM = LONG_W'(UV_CYCLES);
    localparam logic [LONG_W-1:0] START_LIM = LONG_W'(EXT_BLANK_CYCLES);

    bfm_ctl_t state_reg;
    bfm_ctl_t state_next;
    logic [N_CMP:0] s;
    logic op;
    logic in_burst;
    logic start_done;
    logic ol_done;
    logic fault;
    logic [N_SHORT-1:0] sh_cond;

    // saturating qualification counter, cleared when its condition drops
    function automatic logic [LONG_W-1:0] tick_l(input logic [LONG_W-1:0] c,
                                                  input logic cond,
                                                  input logic [LONG_W-1:0] lim);
        logic [LONG_W-1:0] r;
        r = '0;
        if (cond) begin
            r = (c >= lim) ? lim : LONG_W'(c + 1'b1);
        end
        return r;
    endfunction : tick_l

    // comparator synchronisers
    bfm_sync_if #(.W(N_CMP + 1)) cmp_if ();
    assign cmp_if.raw = {over_temp, supply_turn_on, supply_under, supply_over_comparator,
                         supply_softstart_over, ext_restart_level, ramp_level_comparator,
                         overload_comparator, burst_low_comparator, burst_high_comparator,
                         light_load_comparator};
    bfm_sync #(.W(N_CMP + 1)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .sif(cmp_if.syn)
    );
    assign s = cmp_if.sync;

    // state decode and qualified conditions
    assign op = (state_reg.st != ST_RST_WAIT) && (state_reg.st != ST_RST_CHARGE);
    assign in_burst = (state_reg.st == ST_BURST_OFF) || (state_reg.st == ST_BURST_ON);
    assign start_done = (state_reg.start_cnt == START_LIM);
    assign ol_done = (state_reg.ol_cnt == BLANK_LIM);
    assign sh_cond[SQ_OVP_SS] = op && (state_reg.st == ST_SOFT_START)
                                && s[IDX_OV_SS] && s[IDX_OVL];
    assign sh_cond[SQ_OVP_HI] = op && !in_burst && s[IDX_OV_HI];
    assign sh_cond[SQ_OT] = op && s[IDX_OT];
    assign sh_cond[SQ_EXT] = op && start_done && s[IDX_EXT];
    assign sh_cond[SQ_SPIKE] = op && ol_done && s[IDX_RAMP];

    // any qualified fault sends the converter to auto-restart
    always_comb begin
        fault = (state_reg.uv_cnt == UV_LIM);
        for (int i = 0; i < N_SHORT; i++) begin
            if (state_reg.sh_cnt[i] == SHORT_LIM[i]) begin
                fault = 1'b1;
            end
        end
    end

    // next state of the whole controller
    always_comb begin
        state_next = state_reg;
        // light-load counter only runs in normal operation
        state_next.ll_cnt = tick_l(state_reg.ll_cnt,
                                   (state_reg.st == ST_NORMAL) && s[IDX_LIGHT], BLANK_LIM);
        state_next.ol_cnt = tick_l(state_reg.ol_cnt, op && s[IDX_OVL], BLANK_LIM);
        state_next.uv_cnt = tick_l(state_reg.uv_cnt, op && s[IDX_UNDER], UV_LIM);
        state_next.start_cnt = tick_l(state_reg.start_cnt, op, START_LIM);
        for (int i = 0; i < N_SHORT; i++) begin
            if (!sh_cond[i]) begin
                state_next.sh_cnt[i] = '0;
            end else if (state_reg.sh_cnt[i] < SHORT_LIM[i]) begin
                state_next.sh_cnt[i] = SHORT_W'(state_reg.sh_cnt[i] + 1'b1);
            end
        end
        if (op && fault) begin
            state_next.st = ST_RST_WAIT;
        end else begin
            unique case (state_reg.st)
                ST_SOFT_START: begin
                    if (soft_start_done) begin
                        state_next.st = ST_NORMAL;
                    end
                end
                ST_NORMAL: begin
                    if ((state_reg.ll_cnt == BLANK_LIM) && s[IDX_LIGHT]) begin
                        state_next.st = ST_BURST_OFF;
                    end
                end
                ST_BURST_OFF: begin
                    if (s[IDX_OVL]) begin
                        state_next.st = ST_NORMAL;
                    end else if (s[IDX_BHIGH]) begin
                        state_next.st = ST_BURST_ON;
                    end
                end
                ST_BURST_ON: begin
                    if (s[IDX_OVL]) begin
                        state_next.st = ST_NORMAL;
                    end else if (s[IDX_BLOW]) begin
                        state_next.st = ST_BURST_OFF;
                    end
                end
                ST_RST_WAIT: begin
                    if (s[IDX_UNDER]) begin
                        state_next.st = ST_RST_CHARGE;
                    end
                end
                ST_RST_CHARGE: begin
                    if (s[IDX_TURN_ON]) begin
                        state_next.st = ST_SOFT_START;
                    end
                end
            endcase
        end
        // outputs follow the next state
        state_next.burst_flag = (state_next.st == ST_BURST_OFF)
                                || (state_next.st == ST_BURST_ON);
        state_next.reduced_sel = state_next.burst_flag;
        state_next.bias_en = (state_next.st == ST_NORMAL) || (state_next.st == ST_SOFT_START)
                             || (state_next.st == ST_BURST_ON);
        state_next.startup_en = (state_next.st == ST_RST_CHARGE);
        state_next.soft_start_en = (state_next.st == ST_SOFT_START);
        state_next.restart = !state_next.bias_en && !state_next.burst_flag;
        state_next.clamp_release = (state_next.ol_cnt == BLANK_LIM);
        state_next.ext_stop = op && start_done && s[IDX_EXT];
        state_next.gate_ok = state_next.bias_en && !state_next.ext_stop;
    end

    // state register, reset lands in soft start as at power-up
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= '{st: ST_SOFT_START, bias_en: 1'b1, soft_start_en: 1'b1,
                           gate_ok: 1'b1, default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs; the gate request is the switching latch masked by gate_ok
    assign gate_req = pwm_latch_q && state_reg.gate_ok;
    assign burst_flag = state_reg.burst_flag;
    assign bias_en = state_reg.bias_en;
    assign startup_cell_en = state_reg.startup_en;
    assign reduced_limit_gate = state_reg.reduced_sel;
    assign clamp_release_switch = state_reg.clamp_release;
    assign soft_start_en = state_reg.soft_start_en;
    assign auto_restart = state_reg.restart;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_ll_zero;
        state_reg.st == ST_NORMAL && !s[IDX_LIGHT] |=> state_reg.ll_cnt == '0;
    endproperty
    a_ll_zero: assert property (p_ll_zero) else $error("light-load counter not cleared");

    property p_burst_entry;
        state_reg.st == ST_NORMAL && $past(state_reg.st) == ST_NORMAL ##1 state_reg.st == ST_BURST_OFF
            |-> $past(state_reg.ll_cnt) == BLANK_LIM && $past(s[IDX_LIGHT]);
    endproperty
    a_burst_entry: assert property (p_burst_entry) else $error("burst entered early");

    property p_burst_off_outputs;
        state_reg.st == ST_BURST_OFF |-> burst_flag && !bias_en && !startup_cell_en && !gate_req;
    endproperty
    a_burst_off_outputs: assert property (p_burst_off_outputs) else $error("burst-off outputs wrong");

    property p_no_startup_burst;
        in_burst |-> !startup_cell_en && reduced_limit_gate;
    endproperty
    a_no_startup_burst: assert property (p_no_startup_burst) else $error("burst output set wrong");

    property p_burst_wake;
        state_reg.st == ST_BURST_OFF && s[IDX_BHIGH] && !s[IDX_OVL] && !fault
            |=> bias_en && state_reg.st == ST_BURST_ON;
    endproperty
    a_burst_wake: assert property (p_burst_wake) else $error("bias not resumed");

    property p_burst_sleep;
        state_reg.st == ST_BURST_ON && s[IDX_BLOW] && !s[IDX_OVL] && !fault |=> !bias_en;
    endproperty
    a_burst_sleep: assert property (p_burst_sleep) else $error("bias not switched off");

    property p_burst_exit;
        in_burst && s[IDX_OVL] && !fault |=> !reduced_limit_gate && state_reg.st == ST_NORMAL;
    endproperty
    a_burst_exit: assert property (p_burst_exit) else $error("burst not left on overload");

    property p_ovp_hi_off;
        in_burst |=> state_reg.sh_cnt[SQ_OVP_HI] == '0;
    endproperty
    a_ovp_hi_off: assert property (p_ovp_hi_off) else $error("high over-voltage check ran in burst");

    property p_fault_restart;
        op && state_reg.sh_cnt[SQ_OT] == SHORT_LIM[SQ_OT] |=> auto_restart ##1 !gate_req;
    endproperty
    a_fault_restart: assert property (p_fault_restart) else $error("no restart on over-temperature");

    property p_clamp;
        !s[IDX_OVL] |=> !clamp_release_switch;
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp released without overload");

    property p_ext_blank;
        !start_done |=> !state_reg.ext_stop;
    endproperty
    a_ext_blank: assert property (p_ext_blank) else $error("external request not blanked");

    property p_ext_stop;
        op && start_done && s[IDX_EXT] |=> !gate_req;
    endproperty
    a_ext_stop: assert property (p_ext_stop) else $error("gate not stopped");

    property p_uv_restart;
        op && state_reg.uv_cnt == UV_LIM |=> auto_restart;
    endproperty
    a_uv_restart: assert property (p_uv_restart) else $error("no undervoltage restart");

    property p_ovp_ss_only;
        state_reg.st != ST_SOFT_START |=> state_reg.sh_cnt[SQ_OVP_SS] == '0;
    endproperty
    a_ovp_ss_only: assert property (p_ovp_ss_only) else $error("soft-start timer ran");

    property p_restart_seq;
        state_reg.st == ST_RST_CHARGE && s[IDX_TURN_ON]
            |=> soft_start_en && !startup_cell_en && bias_en;
    endproperty
    a_restart_seq: assert property (p_restart_seq) else $error("restart power-up wrong");

    property p_gate_low;
        auto_restart |-> !gate_req;
    endproperty
    a_gate_low: assert property (p_gate_low) else $error("gate driven in restart");

    c_burst: cover property (state_reg.st == ST_BURST_OFF ##1 state_reg.st == ST_BURST_ON);
    c_burst_exit: cover property (in_burst ##1 state_reg.st == ST_NORMAL);
    c_restart: cover property (state_reg.st == ST_RST_CHARGE ##1 state_reg.st == ST_SOFT_START);
    c_clamp: cover property ($rose(clamp_release_switch));

endmodule : bfm_ctrl

// ---- verification/bfm_far_model.sv ----
// Purpose: far side of the controller: comparators, supply, blanking pin, latch, soft start
// Assumes: analog levels in mV and degrees C are set by the bench between clock edges
// Notes:   supply falls in restart and climbs while the startup cell charges
`timescale 1ns/1ps
module bfm_far_model #(
    parameter int SS_CYC = 400,
    parameter int BA_STEP = 100
) (
    input logic clk,
    input int fb_mv,
    input int vcc_set,
    input int tj_c,
    input logic ext_pull,
    input logic auto_restart,
    input logic startup_cell_en,
    input logic soft_start_en,
    input logic clamp_release_switch,
    output logic [10:0] cmp,
    output logic soft_start_done,
    output logic pwm_latch_q
);
    import bfm_pkg::*;
    int vcc_mv = 15000;
    int ba_mv = 900;
    int ba_pin;
    int ss_cnt = 0;
    // supply, blanking capacitor and soft-start ramp move off the sampling edge
    always @(negedge clk) begin
        if (startup_cell_en) begin
            vcc_mv <= vcc_mv + 500;
        end else if (auto_restart) begin
            vcc_mv <= (vcc_mv > 500) ? vcc_mv - 500 : 0;
        end else begin
            vcc_mv <= vcc_set;
        end
        ba_mv <= clamp_release_switch ? ba_mv + BA_STEP : 900;
        ss_cnt <= soft_start_en ? ss_cnt + 1 : 0;
    end
    // oscillator sets the latch every other cycle, synchronous to clk
    bit osc_q = 1'b0;
    always @(posedge clk) begin
        osc_q <= !osc_q;
    end
    assign pwm_latch_q = osc_q;
    // external transistor pulls the pin below the request level
    assign ba_pin = ext_pull ? 200 : ba_mv;
    assign soft_start_done = (ss_cnt >= SS_CYC);
    // comparator levels
    assign cmp[IDX_LIGHT] = (fb_mv < 1350);
    assign cmp[IDX_BHIGH] = (fb_mv > 3500);
    assign cmp[IDX_BLOW] = (fb_mv < 3000);
    assign cmp[IDX_OVL] = (fb_mv > 4000);
    assign cmp[IDX_RAMP] = (ba_pin > 4000);
    assign cmp[IDX_EXT] = (ba_pin < 330);
    assign cmp[IDX_OV_SS] = (vcc_mv > 20500);
    assign cmp[IDX_OV_HI] = (vcc_mv > 25500);
    assign cmp[IDX_UNDER] = (vcc_mv < 10500);
    assign cmp[IDX_TURN_ON] = (vcc_mv >= 18000);
    assign cmp[IDX_OT] = (tj_c > 140);
endmodule : bfm_far_model

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench for the burst and fault mode controller
// Assumes: shortened blanking, under-voltage and start-blanking counts
// Notes:   inputs change at the falling edge, outputs are sampled there too
`timescale 1ns/1ps
module tb_top;
    import bfm_pkg::*;
    localparam int BLANK = 40;
    localparam int UVC = 60;
    localparam int EXTB = 20;
    localparam int O_BI = 2, O_SU = 3, O_CL = 5, O_SS = 6, O_AR = 7, O_BF = 1;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    int fb_mv = 2500;
    int vcc_set = 15000;
    int tj_c = 25;
    logic ext_pull = 1'b0;
    logic [10:0] cmp;
    logic soft_start_done, pwm_latch_q, gate_req, burst_flag, bias_en, startup_cell_en;
    logic reduced_limit_gate, clamp_release_switch, soft_start_en, auto_restart;
    logic [7:0] ov;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    // clock
    always #50 clk = ~clk;
    // device under test
    bfm_ctrl #(.BLANK_CYCLES(BLANK), .UV_CYCLES(UVC), .EXT_BLANK_CYCLES(EXTB)) uut (
        .clk(clk), .rst_n(rst_n),
        .light_load_comparator(cmp[IDX_LIGHT]), .burst_high_comparator(cmp[IDX_BHIGH]),
        .burst_low_comparator(cmp[IDX_BLOW]), .overload_comparator(cmp[IDX_OVL]),
        .ramp_level_comparator(cmp[IDX_RAMP]), .ext_restart_level(cmp[IDX_EXT]),
        .supply_softstart_over(cmp[IDX_OV_SS]), .supply_over_comparator(cmp[IDX_OV_HI]),
        .supply_under(cmp[IDX_UNDER]), .supply_turn_on(cmp[IDX_TURN_ON]),
        .over_temp(cmp[IDX_OT]), .soft_start_done(soft_start_done),
        .pwm_latch_q(pwm_latch_q), .gate_req(gate_req), .burst_flag(burst_flag),
        .bias_en(bias_en), .startup_cell_en(startup_cell_en),
        .reduced_limit_gate(reduced_limit_gate), .clamp_release_switch(clamp_release_switch),
        .soft_start_en(soft_start_en), .auto_restart(auto_restart));
    // far side
    bfm_far_model fm (
        .clk(clk), .fb_mv(fb_mv), .vcc_set(vcc_set), .tj_c(tj_c), .ext_pull(ext_pull),
        .auto_restart(auto_restart), .startup_cell_en(startup_cell_en),
        .soft_start_en(soft_start_en), .clamp_release_switch(clamp_release_switch),
        .cmp(cmp), .soft_start_done(soft_start_done), .pwm_latch_q(pwm_latch_q));
    assign ov = {auto_restart, soft_start_en, clamp_release_switch, reduced_limit_gate,
                 startup_cell_en, bias_en, burst_flag, gate_req};
    // verdict and end of run
    task end_sim;
        if (n_fail == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 15000) begin
            n_fail++;
            end_sim();
        end
    end
    // compare one value
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    // compare a cycle count against a window; a miss reports the nearest bound
    task chk_in(input string nm, input int n, input int lo, input int hi);
        chk(nm, n, (n < lo) ? lo : ((n > hi) ? hi : n));
    endtask : chk_in
    // wait for an output to reach a level, bounded
    task wait_for(input int k, input logic v, input int lim, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (ov[k] !== v && n < lim);
    endtask : wait_for
    // look at the gate while the latch is set
    task gate_chk(input logic exp);
        @(negedge clk);
        if (pwm_latch_q !== 1'b1) @(negedge clk);
        chk("gate_req", gate_req, exp);
    endtask : gate_chk
    // one restart: switched off, charging, powered up into soft start
    task restart_walk;
        int n;
        chk("bias_en", bias_en, 1'b0);
        gate_chk(1'b0);
        vcc_set = 15000;
        wait_for(O_SU, 1'b1, 80, n);
        chk_in("charge wait", n, 1, 70);
        chk("auto_restart", auto_restart, 1'b1);
        wait_for(O_SS, 1'b1, 60, n);
        chk_in("power up wait", n, 1, 50);
        chk("outputs at power up", {startup_cell_en, auto_restart, bias_en}, 3'b001);
    endtask : restart_walk
    // soft start ends and normal running resumes
    task to_normal;
        int n;
        wait_for(O_SS, 1'b0, 500, n);
        chk_in("soft start length", n, 390, 410);
        chk("outputs in normal", ov[7:1], 7'b0000010);
    endtask : to_normal
    // external pull from power-up: blanked first, then stops gate and restarts
    task t_ext;
        int t0;
        int n;
        t0 = cyc;
        chk("outputs after reset", ov[7:1], 7'b0100010);
        ext_pull = 1'b1;
        repeat (EXTB - 6) @(negedge clk);
        gate_chk(1'b1);
        repeat (10) @(negedge clk);
        gate_chk(1'b0);
        chk("auto_restart", auto_restart, 1'b0);
        wait_for(O_AR, 1'b1, 400, n);
        chk_in("external restart", cyc - t0, SPIKE_CYC + EXTB - 2, SPIKE_CYC + EXTB + 8);
        ext_pull = 1'b0;
        restart_walk();
        to_normal();
    endtask : t_ext
    // light load entry, bursts, high supply ignored, load jump exit
    task t_burst;
        int n;
        fb_mv = 1000;
        repeat (BLANK - 10) @(negedge clk);
        fb_mv = 2500;
        repeat (4) @(negedge clk);
        chk("burst_flag", burst_flag, 1'b0);
        fb_mv = 1000;
        wait_for(O_BF, 1'b1, 80, n);
        chk_in("burst entry", n, BLANK, BLANK + 6);
        chk("outputs in burst", ov[4:1], 4'b1001);
        gate_chk(1'b0);
        fb_mv = 3200;
        vcc_set = 26000;
        wait_for(O_AR, 1'b1, 1700, n);
        chk("auto_restart", auto_restart, 1'b0);
        vcc_set = 15000;
        fb_mv = 3600;
        wait_for(O_BI, 1'b1, 8, n);
        chk_in("bias on", n, 1, 5);
        gate_chk(1'b1);
        chk("startup_cell_en", startup_cell_en, 1'b0);
        fb_mv = 2900;
        wait_for(O_BI, 1'b0, 8, n);
        chk_in("bias off", n, 1, 5);
        chk("burst_flag", burst_flag, 1'b1);
        fb_mv = 4100;
        wait_for(O_BF, 1'b0, 8, n);
        chk_in("burst exit", n, 1, 5);
        chk("reduced_limit_gate", reduced_limit_gate, 1'b0);
        fb_mv = 2500;
        repeat (4) @(negedge clk);
    endtask : t_burst
    // overload: clamp opens after blanking, pin ramps, spike blanking, restart
    task t_overload;
        int n;
        fb_mv = 4100;
        wait_for(O_CL, 1'b1, 80, n);
        chk_in("clamp release", n, BLANK, BLANK + 6);
        wait_for(O_AR, 1'b1, 500, n);
        chk_in("overload restart", n, SPIKE_CYC + 30, SPIKE_CYC + 40);
        fb_mv = 2500;
        restart_walk();
        to_normal();
    endtask : t_overload
    // direct faults: high supply, over-temperature (kept on once), under-voltage
    task t_direct(input int k, input int lim);
        int n;
        case (k)
            0: vcc_set = 26000;
            1: tj_c = 150;
            default: vcc_set = 9000;
        endcase
        wait_for(O_AR, 1'b1, lim + 20, n);
        chk_in("fault restart", n, lim, lim + 6);
        chk("clamp_release_switch", clamp_release_switch, 1'b0);
        if (k == 1) begin
            restart_walk();
            wait_for(O_AR, 1'b1, SPIKE_CYC + 20, n);
            chk_in("fault persists", n, SPIKE_CYC, SPIKE_CYC + 6);
        end
        tj_c = 25;
        restart_walk();
    endtask : t_direct
    // over-voltage with feedback high inside soft start
    task t_ov_ss;
        int n;
        vcc_set = 21000;
        fb_mv = 4100;
        wait_for(O_AR, 1'b1, SPIKE_CYC + 20, n);
        chk_in("soft start overvoltage", n, SPIKE_CYC, SPIKE_CYC + 6);
        fb_mv = 2500;
        restart_walk();
    endtask : t_ov_ss
    // main sequence
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        t_ext();
        t_burst();
        t_overload();
        t_direct(0, OVP_HI_CYC);
        to_normal();
        t_direct(1, SPIKE_CYC);
        to_normal();
        t_direct(2, UVC);
        t_ov_ss();
        to_normal();
        end_sim();
    end
endmodule : tb_top
